// ===== src/compare_ctrl_pkg.sv
// Package with register map, field positions and reset values for the compare control block
package compare_ctrl_pkg;
  localparam logic [7:0]  CTRL_TWO_ADDR   = 8'h00;
  localparam logic [7:0]  CTRL_ONE_ADDR   = 8'h04;
  localparam logic [7:0]  COMPARE_ADDR    = 8'h08;
  localparam logic [7:0]  PERIOD_ADDR     = 8'h0C;
  localparam logic [7:0]  STATUS_ADDR     = 8'h10;
  localparam int          FAULT_EXIT_BIT  = 15;
  localparam int          FAULT_LEVEL_BIT = 14;
  localparam int          FAULT_HIZ_BIT   = 13;
  localparam int          INVERT_BIT      = 12;
  localparam int          CASCADE_BIT     = 8;
  localparam int          TRIG_SEL_BIT    = 7;
  localparam int          TRIG_STAT_BIT   = 6;
  localparam int          PIN_HIZ_BIT     = 5;
  localparam int          SRC_LSB         = 0;
  localparam int          SRC_WIDTH       = 5;
  localparam logic [15:0] CTRL_TWO_MASK   = 16'hF1FF;
  localparam logic [15:0] CTRL_TWO_RESET  = 16'h000C;
  localparam int          ENABLE_BIT      = 0;
  localparam int          FAULT_FLAG_BIT  = 0;
  localparam int          FAULT_MODE_BIT  = 1;
  localparam int          SYNC_STAGES     = 3;
endpackage : compare_ctrl_pkg

// ===== src/pin_sync.sv
// Three-stage synchroniser that accepts a change once stages two and three agree
`timescale 1ns/10ps
module pin_sync
  import compare_ctrl_pkg::*;
#(
  parameter int WIDTH = 1
)(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic [WIDTH-1:0] pin_i,
  output logic      [WIDTH-1:0] level_o
);
  logic [WIDTH-1:0] stage [SYNC_STAGES];
  wire  [WIDTH-1:0] agree = ~(stage[1] ^ stage[2]);
  wire  [WIDTH-1:0] next_level = (agree & stage[2]) | (~agree & level_o);

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage[0] <= '0;
      stage[1] <= '0;
      stage[2] <= '0;
      level_o  <= '0;
    end
    else
    begin
      stage[0] <= pin_i;
      stage[1] <= stage[0];
      stage[2] <= stage[1];
      level_o  <= next_level;
    end
  end
endmodule : pin_sync

// ===== src/compare_timer.sv
// Compare timer: counts under a run enable, wraps at the period, drives its output while the count is below the compare value
`timescale 1ns/10ps
module compare_timer
#(
  parameter int WIDTH = 16
)(
  input  wire logic             clk_i,
  input  wire logic             rst_i,
  input  wire logic             run_i,
  input  wire logic             restart_i,
  input  wire logic [WIDTH-1:0] period_i,
  input  wire logic [WIDTH-1:0] compare_i,
  output logic      [WIDTH-1:0] count_o,
  output logic                  period_start_o,
  output logic                  out_o
);
  if (WIDTH < 2 || WIDTH > 32)
  begin : g_bad_width
    $error("compare_timer width out of range");
  end

  wire wrap = run_i && (count_o >= period_i);

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i || restart_i)
      count_o <= '0;
    else if (wrap)
      count_o <= '0;
    else
      count_o <= count_o + 1'b1;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      period_start_o <= 1'b0;
      out_o          <= 1'b0;
    end
    else
    begin
      period_start_o <= wrap || restart_i;
      out_o          <= run_i && (count_o < compare_i);
    end
  end
endmodule : compare_timer

// ===== src/compare_channel.sv
// Output compare channel with fault, invert, cascade, trigger and pin tri-state control
// What this block and the software using it must do
// RQ1: With fault exit select set, fault mode ends only when the fault is gone, software cleared the flag and a period began.
// RQ2: With fault exit select clear, fault mode ends when the fault is gone and a new period begins.
// RQ3: In a fault with the pin driven, the output goes to the fault drive level.
// RQ4: With fault hi-z enable set the pin floats on a fault, otherwise the drive level sets it.
// RQ5: With output invert set the pin shows the inverse of the compare output.
// RQ6: Bits eleven to nine ignore writes and read as zero.
// RQ7: With cascade enable set two channels form one 32-bit compare unit.
// RQ8: With trigger or sync select set the channel starts on a trigger, else it syncs to the source.
// RQ9: Trigger status reads one when the timer runs, and while zero the timer is held at zero. The code holds it only in trigger mode.
// RQ10: With pin hi-z select set the output floats, otherwise it is driven.
// RQ11: The channel pulses a trigger-out when it is turned off.
// RQ12: Software never selects a channel as its own sync or trigger source.
// RQ13: Software deselects a trigger source before disabling that channel.
// RQ14: Reset loads the source select field with 01100 and clears the other bits.
// RQ15: In trigger mode the source sets trigger status, which stays until software writes zero.
//
// The register addresses and register access over Wishbone are this design's own decisions.
`timescale 1ns/10ps
module compare_channel
  import compare_ctrl_pkg::*;
#(
  parameter int SOURCES = 32
)(
  input  wire logic               clk_i,
  input  wire logic               rst_i,
  input  wire logic               wb_cyc_i,
  input  wire logic               wb_stb_i,
  input  wire logic               wb_we_i,
  input  wire logic [7:0]         wb_adr_i,
  input  wire logic [3:0]         wb_sel_i,
  input  wire logic [31:0]        wb_dat_i,
  output logic      [31:0]        wb_dat_o,
  output logic                    wb_ack_o,
  input  wire logic               fault_i,
  input  wire logic [SOURCES-1:0] source_i,
  input  wire logic               peer_count_wrap_i,
  output logic                    pin_o,
  output logic                    pin_oe_n_o,
  output logic                    trigger_out_o,
  output logic                    count_wrap_o
);
  if (SOURCES < 1 || SOURCES > 32)
  begin : g_bad_sources
    $error("compare_channel source count out of range");
  end

  logic [15:0] ctrl_two;
  logic [15:0] ctrl_one;
  logic [31:0] compare_val;
  logic [31:0] period_val;
  logic        fault_flag;
  logic        fault_mode;
  logic        fault_sync;
  logic        source_prev;
  logic [31:0] count;
  logic        period_start;
  logic        raw_out;
  logic        pin_reg;
  logic        oe_n_reg;

  // Bus decode
  wire bus_req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
  wire bus_wr    = bus_req && wb_we_i;
  wire lo_lanes  = wb_sel_i[0] || wb_sel_i[1];
  wire hit_two   = (wb_adr_i == CTRL_TWO_ADDR);
  wire hit_one   = (wb_adr_i == CTRL_ONE_ADDR);
  wire hit_cmp   = (wb_adr_i == COMPARE_ADDR);
  wire hit_per   = (wb_adr_i == PERIOD_ADDR);
  wire hit_stat  = (wb_adr_i == STATUS_ADDR);

  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge16 = {sel[1] ? d[15:8] : old[15:8], sel[0] ? d[7:0] : old[7:0]};
  endfunction : merge16

  function automatic logic [31:0] merge32(input logic [31:0] old, input logic [31:0] d,
                                          input logic [3:0] sel);
    merge32 = {merge16(old[31:16], {16'h0000, d[31:16]}, {2'b00, sel[3:2]}),
               merge16(old[15:0], d, sel)};
  endfunction : merge32

  wire        enabled     = ctrl_one[ENABLE_BIT];
  wire        fault_exit  = ctrl_two[FAULT_EXIT_BIT];
  wire        fault_level = ctrl_two[FAULT_LEVEL_BIT];
  wire        fault_hiz   = ctrl_two[FAULT_HIZ_BIT];
  wire        invert      = ctrl_two[INVERT_BIT];
  wire        cascade     = ctrl_two[CASCADE_BIT];
  wire        trig_mode   = ctrl_two[TRIG_SEL_BIT];
  wire        trig_stat   = ctrl_two[TRIG_STAT_BIT];
  wire        pin_hiz     = ctrl_two[PIN_HIZ_BIT];
  wire [4:0]  src_sel     = ctrl_two[SRC_LSB +: SRC_WIDTH];

  // Selected sync or trigger source, edge detected
  wire        src_level   = (32'(src_sel) < SOURCES) ? source_i[src_sel] : 1'b0;
  wire        src_event   = src_level && !source_prev;

  // Software write to control register two, reserved bits forced to zero
  wire        wr_two      = bus_wr && hit_two && lo_lanes;
  wire [15:0] wr_two_val  = merge16(ctrl_two, wb_dat_i, wb_sel_i) & CTRL_TWO_MASK; // see RQ6
  wire        trig_set    = enabled && trig_mode && src_event;                     // see RQ15
  wire        next_trig   = trig_set ? 1'b1 : (wr_two ? wr_two_val[TRIG_STAT_BIT] : trig_stat);
  wire [15:0] next_two    = wr_two ? wr_two_val : ctrl_two;

  // Fault flag: set by fault input, software clears by writing one, set wins
  wire        clr_flag    = bus_wr && hit_stat && wb_sel_i[0] && wb_dat_i[FAULT_FLAG_BIT];
  wire        next_flag   = fault_sync ? 1'b1 : (clr_flag ? 1'b0 : fault_flag);

  // Fault exit conditions
  wire        exit_ready  = !fault_sync && (!fault_exit || !fault_flag);             // see RQ1
  wire        next_fmode  = fault_sync ? 1'b1 :
                            ((fault_mode && exit_ready && period_start) ? 1'b0 : fault_mode); // see RQ2

  // Timer run and restart: trigger mode waits on status, sync mode restarts on source
  wire        run         = enabled && (!trig_mode || trig_stat);                   // see RQ9
  wire        restart     = enabled && !trig_mode && src_event;                     // see RQ8
  wire        timer_restart = restart || (cascade && peer_count_wrap_i);            // see RQ7
  wire [31:0] eff_period  = cascade ? period_val : {16'h0000, period_val[15:0]};    // see RQ7
  wire [31:0] eff_compare = cascade ? compare_val : {16'h0000, compare_val[15:0]};

  // Output path
  wire        shaped_out  = raw_out ^ invert;                                       // see RQ5
  wire        next_pin    = fault_mode ? fault_level : shaped_out;                  // see RQ3
  wire        next_oe_n   = pin_hiz || (fault_mode && fault_hiz);                   // see RQ4, RQ10

  wire [31:0] rd_data     = hit_two  ? {16'h0000, ctrl_two} :
                            hit_one  ? {16'h0000, ctrl_one} :
                            hit_cmp  ? compare_val :
                            hit_per  ? period_val :
                            hit_stat ? {30'h0, fault_mode, fault_flag} : 32'h0000_0000;

  // Fault source may come from a pin, so it is synchronised first
  pin_sync #(
    .WIDTH   (1)
  ) u_fault_sync (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (fault_i),
    .level_o (fault_sync)
  );

  compare_timer #(
    .WIDTH          (32)
  ) u_timer (
    .clk_i          (clk_i),
    .rst_i          (rst_i),
    .run_i          (run),
    .restart_i      (timer_restart),
    .period_i       (eff_period),
    .compare_i      (eff_compare),
    .count_o        (count),
    .period_start_o (period_start),
    .out_o          (raw_out)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl_two <= CTRL_TWO_RESET;                                                    // see RQ14
      ctrl_one <= 16'h0000;
    end
    else
    begin
      ctrl_two <= {next_two[15:7], next_trig, next_two[5:0]};
      if (bus_wr && hit_one)
        ctrl_one <= merge16(ctrl_one, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      compare_val <= 32'h0000_0000;
      period_val  <= 32'hFFFF_FFFF;
    end
    else
    begin
      if (bus_wr && hit_cmp)
        compare_val <= merge32(compare_val, wb_dat_i, wb_sel_i);
      if (bus_wr && hit_per)
        period_val <= merge32(period_val, wb_dat_i, wb_sel_i);
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      fault_flag    <= 1'b0;
      fault_mode    <= 1'b0;
      source_prev   <= 1'b0;
      pin_reg       <= 1'b0;
      oe_n_reg      <= 1'b0;
      trigger_out_o <= 1'b0;
      wb_ack_o      <= 1'b0;
      wb_dat_o      <= 32'h0000_0000;
    end
    else
    begin
      fault_flag    <= next_flag;
      fault_mode    <= next_fmode;
      source_prev   <= src_level;
      pin_reg       <= next_pin;
      oe_n_reg      <= next_oe_n;
      trigger_out_o <= bus_wr && hit_one && wb_sel_i[0] && enabled
                       && !wb_dat_i[ENABLE_BIT];                                     // see RQ11
      wb_ack_o      <= bus_req;
      wb_dat_o      <= bus_req ? rd_data : wb_dat_o;
    end
  end

  assign pin_o        = pin_reg;
  assign pin_oe_n_o   = oe_n_reg;
  assign count_wrap_o = period_start;

  // Timer run, restart and trigger status
  stat_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)                // see RQ9
    !trig_stat && trig_mode |=> count == 0)
    else $error("timer not held while trigger status low");
  timer_run_a: assert property (@(posedge clk_i) disable iff (rst_i)                // see RQ9
    run && !timer_restart && count < eff_period |=> count == $past(count) + 32'h0000_0001)
    else $error("running timer did not advance");
  trig_set_a: assert property (@(posedge clk_i) disable iff (rst_i)                 // see RQ15
    trig_set |=> trig_stat)
    else $error("trigger status not set by source");
  stat_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)               // see RQ15
    wr_two && !wr_two_val[TRIG_STAT_BIT] && !trig_set |=> !trig_stat)
    else $error("trigger status not cleared by software");
  sync_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)             // see RQ8
    restart |=> count == 0)
    else $error("sync source did not restart timer");
  peer_restart_a: assert property (@(posedge clk_i) disable iff (rst_i)             // see RQ7
    cascade && peer_count_wrap_i |=> count == 0)
    else $error("peer wrap did not restart cascaded timer");
  period_wrap_a: assert property (@(posedge clk_i) disable iff (rst_i)              // see RQ2
    run && count >= eff_period |=> count == 0)
    else $error("timer did not wrap at period");

  // Fault entry, hold and exit
  flag_set_a: assert property (@(posedge clk_i) disable iff (rst_i)                 // see RQ1
    fault_sync |=> fault_flag)
    else $error("fault flag not set by fault");
  flag_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)               // see RQ1
    clr_flag && !fault_sync |=> !fault_flag)
    else $error("fault flag not cleared by software");
  fault_enter_a: assert property (@(posedge clk_i) disable iff (rst_i)              // see RQ3
    fault_sync |=> fault_mode)
    else $error("fault mode not entered");
  fault_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)               // see RQ1
    fault_mode && fault_exit && fault_flag |=> fault_mode)
    else $error("fault mode left with flag set");
  fault_exit_a: assert property (@(posedge clk_i) disable iff (rst_i)               // see RQ2
    fault_mode && !fault_exit && !fault_sync && period_start |=> !fault_mode)
    else $error("fault mode not left at period start");

  // Pin level and drive
  fault_drive_a: assert property (@(posedge clk_i) disable iff (rst_i)              // see RQ3
    fault_mode && !fault_hiz && !pin_hiz |=> pin_o == $past(fault_level))
    else $error("fault drive level wrong");
  fault_hiz_a: assert property (@(posedge clk_i) disable iff (rst_i)                // see RQ4
    fault_mode && fault_hiz |=> pin_oe_n_o)
    else $error("pin not floated on fault");
  pin_hiz_a: assert property (@(posedge clk_i) disable iff (rst_i)                  // see RQ10
    pin_hiz |=> pin_oe_n_o)
    else $error("pin not floated by pin hi-z select");
  pin_driven_a: assert property (@(posedge clk_i) disable iff (rst_i)               // see RQ10
    !pin_hiz && !(fault_mode && fault_hiz) |=> !pin_oe_n_o)
    else $error("pin not driven");
  invert_out_a: assert property (@(posedge clk_i) disable iff (rst_i)               // see RQ5
    !fault_mode |=> pin_o == ($past(raw_out) ^ $past(invert)))
    else $error("output invert wrong");

  // Register contents and turn-off pulse
  reserved_zero_a: assert property (@(posedge clk_i) disable iff (rst_i)            // see RQ6
    ctrl_two[11:9] == 3'b000)
    else $error("reserved bits not zero");
  reset_value_a: assert property (@(posedge clk_i) disable iff (rst_i)              // see RQ14
    $past(rst_i) |-> ctrl_two == CTRL_TWO_RESET)
    else $error("control register two wrong after reset");
  off_pulse_a: assert property (@(posedge clk_i) disable iff (rst_i)                // see RQ11
    $fell(enabled) && !$past(rst_i) |-> trigger_out_o)
    else $error("no trigger out on turn off");
  off_only_a: assert property (@(posedge clk_i) disable iff (rst_i)                 // see RQ11
    trigger_out_o |-> !enabled)
    else $error("trigger out while still enabled");
endmodule : compare_channel

// ===== testbench/chan_partner.sv
// Far-side model: fault source, peer triggers, peer wrap and a pulled-up pin
`timescale 1ns/10ps
module chan_partner (
  input  wire logic        clk_i,
  input  wire logic        fault_req_i,
  input  wire logic        trig_req_i,
  input  wire logic [4:0]  trig_idx_i,
  input  wire logic        wrap_req_i,
  input  wire logic        pin_i,
  input  wire logic        pin_oe_n_i,
  output logic             fault_o,
  output logic [31:0]      source_o,
  output logic             peer_wrap_o,
  output logic             pad_o
);
  // Peer trigger and wrap arrive as one-cycle pulses
  always @(posedge clk_i)
  begin
    fault_o     <= fault_req_i;
    source_o    <= trig_req_i ? (32'h1 << trig_idx_i) : 32'h0;
    peer_wrap_o <= wrap_req_i;
  end
  // A floating pin is pulled high
  assign pad_o = pin_oe_n_i ? 1'b1 : pin_i;
endmodule : chan_partner

// ===== testbench/tb.sv
// Self-checking bench for the compare channel
`timescale 1ns/10ps
module tb;
  import compare_ctrl_pkg::*;
  localparam int OWN_IDX = 3;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        cyc = 1'b0, stb = 1'b0, we = 1'b0;
  logic [7:0]  adr = 8'h00;
  logic [3:0]  sel = 4'h0;
  logic [31:0] wdat = 32'h0, rdat, q, source;
  logic        ack, pin, oe_n, trig_out, wrap, fault, peer_wrap, pad, p0;
  logic        fault_req = 1'b0, trig_req = 1'b0, wrap_req = 1'b0;
  logic [4:0]  trig_idx = 5'h00, s;
  logic [15:0] v;
  int          n_errors = 0, checks = 0, n_wrap = 0, n_toff = 0, w0;
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i)
  begin
    n_wrap <= n_wrap + 32'(wrap === 1'b1);
    n_toff <= n_toff + 32'(trig_out === 1'b1);
  end
  compare_channel i_compare_channel (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
    .wb_dat_o(rdat), .wb_ack_o(ack), .fault_i(fault), .source_i(source),
    .peer_count_wrap_i(peer_wrap), .pin_o(pin), .pin_oe_n_o(oe_n),
    .trigger_out_o(trig_out), .count_wrap_o(wrap));
  chan_partner i_chan_partner (.clk_i(clk_i), .fault_req_i(fault_req),
    .trig_req_i(trig_req), .trig_idx_i(trig_idx), .wrap_req_i(wrap_req), .pin_i(pin),
    .pin_oe_n_i(oe_n), .fault_o(fault), .source_o(source), .peer_wrap_o(peer_wrap),
    .pad_o(pad));
  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wait_clk
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc  <= 1'b1;
    stb  <= 1'b1;
    we   <= w;
    adr  <= a;
    wdat <= d;
    sel  <= (a < 8'h08) ? 4'h3 : 4'hF;
    do
    begin
      @(posedge clk_i);
      n++;
    end
    while (ack !== 1'b1 && n < 100);
    if (n >= 100)
      n_errors++;
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rd
  task automatic pulse_src(input logic [4:0] i);
    trig_idx <= i;
    trig_req <= 1'b1;
    wait_clk(1);
    trig_req <= 1'b0;
  endtask : pulse_src
  task automatic complete_run;
    $display("Checks %0d, errors %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : complete_run
  initial
  begin
    #1000000;
    n_errors++;
    complete_run();
  end
  initial
  begin
    void'($urandom(1));
    wait_clk(5);
    rst_i <= 1'b0;
    rd(CTRL_TWO_ADDR, 32'h0000_000C);
    rd(CTRL_ONE_ADDR, 32'h0000_0000);
    rd(PERIOD_ADDR, 32'hFFFF_FFFF);
    wr(8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0000_0000);
    for (int i = 0; i < 8; i++)
    begin
      v = (i == 0) ? 16'hFFBF : 16'($urandom) & 16'hFFBF;
      wr(CTRL_TWO_ADDR, {16'h0, v});
      rd(CTRL_TWO_ADDR, {16'h0, v & 16'hF1FF});
    end
    wr(CTRL_TWO_ADDR, 32'h0000_002C);
    wait_clk(3);
    chk({30'h0, oe_n, pad}, 32'h3);
    wr(CTRL_TWO_ADDR, 32'h0000_000C);
    wait_clk(3);
    chk({31'h0, oe_n}, 32'h0);
    $display("test registers done");
    wr(PERIOD_ADDR, 32'h0000_FFFF);
    wr(COMPARE_ADDR, 32'h0000_FFFF);
    wr(CTRL_ONE_ADDR, 32'h1);
    wait_clk(5);
    p0 = pin;
    wr(CTRL_TWO_ADDR, 32'h0000_100C);
    wait_clk(3);
    chk({31'h0, pin}, {31'h0, ~p0});
    wr(CTRL_TWO_ADDR, 32'h0000_000C);
    wait_clk(3);
    chk({31'h0, pin}, {31'h0, p0});
    $display("test invert done");
    wr(PERIOD_ADDR, 32'h0000_000F);
    wr(COMPARE_ADDR, 32'h0000_0008);
    pulse_src(5'h0C);
    wait_clk(3);
    w0 = n_wrap;
    repeat (4)
    begin
      pulse_src(5'h0C);
      wait_clk(9);
    end
    chk(32'(n_wrap - w0), 32'h4);
    wr(CTRL_TWO_ADDR, 32'h0000_C00C);
    fault_req <= 1'b1;
    wait_clk(10);
    chk({30'h0, oe_n, pin}, 32'h1);
    rd(STATUS_ADDR, 32'h3);
    wr(CTRL_TWO_ADDR, 32'h0000_E00C);
    wait_clk(3);
    chk({30'h0, oe_n, pad}, 32'h3);
    wr(CTRL_TWO_ADDR, 32'h0000_800C);
    wait_clk(3);
    chk({30'h0, oe_n, pin}, 32'h0);
    fault_req <= 1'b0;
    wait_clk(40);
    rd(STATUS_ADDR, 32'h3);
    wr(STATUS_ADDR, 32'h1);
    wait_clk(40);
    rd(STATUS_ADDR, 32'h0);
    wr(CTRL_TWO_ADDR, 32'h0000_000C);
    fault_req <= 1'b1;
    wait_clk(5);
    fault_req <= 1'b0;
    wait_clk(40);
    rd(STATUS_ADDR, 32'h1);
    wr(STATUS_ADDR, 32'h1);
    $display("test fault done");
    w0 = n_toff;
    wr(CTRL_ONE_ADDR, 32'h0);
    wait_clk(5);
    chk(32'(n_toff - w0), 32'h1);
    s = 5'($urandom_range(31));
    if (s == OWN_IDX)
      s = s + 5'h1;
    wr(CTRL_TWO_ADDR, {24'h0, 3'b100, s});
    wr(CTRL_ONE_ADDR, 32'h1);
    w0 = n_wrap;
    wait_clk(40);
    chk(32'(n_wrap - w0), 32'h0);
    rd(CTRL_TWO_ADDR, {24'h0, 3'b100, s});
    pulse_src(s);
    wait_clk(40);
    rd(CTRL_TWO_ADDR, {24'h0, 3'b110, s});
    chk(32'(n_wrap > w0 + 1), 32'h1);
    wr(CTRL_TWO_ADDR, {24'h0, 3'b100, s});
    wait_clk(3);
    w0 = n_wrap;
    wait_clk(40);
    chk(32'(n_wrap - w0), 32'h0);
    wr(CTRL_TWO_ADDR, 32'h0000_000C);
    $display("test trigger done");
    wr(PERIOD_ADDR, 32'h0001_0004);
    wr(COMPARE_ADDR, 32'h0000_0002);
    w0 = n_wrap;
    wait_clk(30);
    chk(32'(n_wrap > w0 + 2), 32'h1);
    wr(CTRL_TWO_ADDR, 32'h0000_010C);
    wait_clk(3);
    w0 = n_wrap;
    wait_clk(60);
    chk(32'(n_wrap - w0), 32'h0);
    wrap_req <= 1'b1;
    wait_clk(1);
    wrap_req <= 1'b0;
    wait_clk(3);
    chk(32'(n_wrap - w0), 32'h1);
    $display("test cascade done");
    rst_i <= 1'b1;
    wait_clk(5);
    rst_i <= 1'b0;
    rd(CTRL_TWO_ADDR, 32'h0000_000C);
    $display("test reset done");
    complete_run();
  end
endmodule : tb
